/* src/fpw_field.sv */
// Module: one writable register field with reset value and load strobe
`timescale 1ns/1ns
`default_nettype none
module fpw_field #(
  parameter int              WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] val_q;
  logic [WIDTH-1:0] val_d;

  // A zero-width field cannot hold anything
  if (WIDTH < 1) begin
    $error("fpw_field WIDTH must be at least 1");
  end

  always_comb begin
    val_d = load ? din : val_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      val_q <= RESET;
    end else begin
      val_q <= val_d;
    end
  end

  assign dout = val_q;
endmodule
`default_nettype wire

/* src/fpw_pkg.sv */
// Package: register map, field layout and types for the pull offset word bank
package fpw_pkg;
  localparam int          FPW_ADDR_W        = 8;
  localparam int          FPW_DATA_W        = 16;
  localparam int          FPW_OFFSET_W      = 26;
  localparam int          FPW_LOW_W         = 16;
  localparam int          FPW_HIGH_W        = 10;
  localparam logic [7:0]  FPW_ADDR_LOW      = 8'h00;
  localparam logic [7:0]  FPW_ADDR_HIGH     = 8'h01;
  localparam int          FPW_HIGH_LSB      = 0;
  localparam int          FPW_OE_BIT        = 10;
  localparam logic [15:0] FPW_LOW_RESET     = 16'h0000;
  localparam logic [9:0]  FPW_HIGH_RESET    = 10'h000;
  localparam logic        FPW_OE_RESET      = 1'b0;
  localparam logic [25:0] FPW_FULL_SCALE    = 26'h1FFFFFF;
  // Fewest clocks between two applies for a host keeping the 38 kHz limit at 125 MHz
  localparam int          FPW_UPD_GAP_CYC   = 3290;

  typedef struct packed {
    logic                 wr_en;
    logic                 rd_en;
    logic [7:0]           addr;
    logic [15:0]          wdata;
  } fpw_req_t;

  typedef struct packed {
    logic                 rd_valid;
    logic [15:0]          rdata;
  } fpw_rsp_t;
endpackage

/* src/fpw_regs.sv */
// Module: pull offset word register bank with staged apply and output enable
`timescale 1ns/1ns
`default_nettype none
module fpw_regs
  import fpw_pkg::*;
(
  input  wire logic                            clk_sys,
  input  wire logic                            rst_n,
  input  wire fpw_req_t                        req,
  output fpw_rsp_t                             rsp,
  input  wire logic                            oe_sw_mode,
  input  wire logic                            oe_pin,
  output logic signed [FPW_OFFSET_W-1:0]       signed_pull_offset,
  output logic                                 offset_update,
  output logic                                 out_enable
);

  // Reserved bits above the enable bit read as zero
  localparam int                      RSVD_W        = FPW_DATA_W - FPW_OE_BIT - 1;
  localparam logic [FPW_OFFSET_W-1:0] APPLIED_RESET = {FPW_HIGH_RESET, FPW_LOW_RESET};

  logic                    wr_low;
  logic                    wr_high;
  logic                    rd_low;
  logic                    rd_high;
  logic                    oe_load;

  logic [FPW_LOW_W-1:0]    low_word;
  logic [FPW_HIGH_W-1:0]   high_word;
  logic                    oe_bit;

  logic [FPW_OFFSET_W-1:0] applied_q;
  logic [FPW_OFFSET_W-1:0] applied_d;
  logic                    update_q;
  logic                    update_d;
  logic                    out_en_q;
  logic                    out_en_d;
  logic [FPW_DATA_W-1:0]   high_image;
  fpw_rsp_t                rsp_q;
  fpw_rsp_t                rsp_d;

  // The read image below packs the fields from bit 0 upward
  if (FPW_LOW_W + FPW_HIGH_W != FPW_OFFSET_W) begin
    $error("Low and high word widths must add up to the offset width");
  end
  if (FPW_LOW_W != FPW_DATA_W) begin
    $error("Low word must fill the bus word");
  end
  if (FPW_HIGH_LSB != 0 || FPW_HIGH_W != FPW_OE_BIT) begin
    $error("High word must start at bit 0 and end just below the enable bit");
  end
  if (RSVD_W < 1) begin
    $error("Enable bit must leave reserved bits above it");
  end
  if (FPW_ADDR_LOW == FPW_ADDR_HIGH) begin
    $error("The two registers need distinct addresses");
  end

  // Strobes to an unmapped address hit nothing
  always_comb begin
    wr_low  = req.wr_en && (req.addr == FPW_ADDR_LOW);
    wr_high = req.wr_en && (req.addr == FPW_ADDR_HIGH);
    rd_low  = req.rd_en && (req.addr == FPW_ADDR_LOW);
    rd_high = req.rd_en && (req.addr == FPW_ADDR_HIGH);
    // Hardware pin mode leaves the stored bit untouched
    oe_load = wr_high && oe_sw_mode;
  end

  // Low word is only staging; it never reaches the synthesizer alone
  fpw_field #(.WIDTH(FPW_LOW_W), .RESET(FPW_LOW_RESET)) u_low (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .load    (wr_low),
    .din     (req.wdata[FPW_LOW_W-1:0]),
    .dout    (low_word)
  );

  fpw_field #(.WIDTH(FPW_HIGH_W), .RESET(FPW_HIGH_RESET)) u_high (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .load    (wr_high),
    .din     (req.wdata[FPW_HIGH_LSB +: FPW_HIGH_W]),
    .dout    (high_word)
  );

  fpw_field #(.WIDTH(1), .RESET(FPW_OE_RESET)) u_oe (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .load    (oe_load),
    .din     (req.wdata[FPW_OE_BIT]),
    .dout    (oe_bit)
  );

  // Bus data feeds the top bits so the new high word and staged low land together
  always_comb begin
    applied_d = applied_q;
    if (wr_high) begin
      applied_d = {req.wdata[FPW_HIGH_LSB +: FPW_HIGH_W], low_word};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      applied_q <= APPLIED_RESET;
    end else begin
      applied_q <= applied_d;
    end
  end

  // One-cycle strobe marks each new applied word for the downstream synthesizer
  always_comb begin
    update_d = wr_high;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      update_q <= 1'b0;
    end else begin
      update_q <= update_d;
    end
  end

  // Pin mode follows the pin; software mode follows the stored bit or its write
  always_comb begin
    out_en_d = oe_pin;
    if (oe_sw_mode) begin
      out_en_d = oe_load ? req.wdata[FPW_OE_BIT] : oe_bit;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      out_en_q <= FPW_OE_RESET;
    end else begin
      out_en_q <= out_en_d;
    end
  end

  // Unmapped reads still answer, with zero data
  always_comb begin
    high_image     = {{RSVD_W{1'b0}}, oe_bit, high_word};
    rsp_d          = '0;
    rsp_d.rd_valid = req.rd_en;
    if (rd_low) begin
      rsp_d.rdata = low_word;
    end else if (rd_high) begin
      rsp_d.rdata = high_image;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // Scaling to the pull range happens downstream; full scale is FPW_FULL_SCALE
  assign signed_pull_offset = applied_q;
  assign offset_update      = update_q;
  assign out_enable         = out_en_q;
  assign rsp                = rsp_q;
endmodule
`default_nettype wire

/* verification/fpw_regs_sva.sv */
// Checker: read timing, staged apply and enable relations
`timescale 1ns/1ns
`default_nettype none
module fpw_regs_sva
  import fpw_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rst_n,
  input wire fpw_req_t           req,
  input wire fpw_rsp_t           rsp,
  input wire logic               oe_sw_mode,
  input wire logic               oe_pin,
  input wire logic signed [25:0] signed_pull_offset,
  input wire logic               offset_update,
  input wire logic               out_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire hi = req.wr_en && req.addr == FPW_ADDR_HIGH;
  AST_RD: assert property (req.rd_en |=> rsp.rd_valid)
    else $error("no read answer");
  AST_RD_IDLE: assert property (!req.rd_en |=> !rsp.rd_valid && rsp.rdata == 16'h0000)
    else $error("read answer without a read");
  AST_UPD: assert property (hi |=> offset_update)
    else $error("no apply");
  AST_NOUPD: assert property (!hi |=> !offset_update)
    else $error("stray apply");
  AST_APPLY: assert property (hi |=> signed_pull_offset[25:16] == $past(req.wdata[9:0]))
    else $error("bad high bits");
  AST_HOLD: assert property ($past(rst_n) && !offset_update |-> $stable(signed_pull_offset))
    else $error("offset moved");
  AST_OE_SW: assert property (hi && oe_sw_mode |=> out_enable == $past(req.wdata[10]))
    else $error("bad sw enable");
  AST_OE_HW: assert property (!oe_sw_mode |=> out_enable == $past(oe_pin))
    else $error("bad pin enable");
  AST_RSVD: assert property (req.rd_en && req.addr == FPW_ADDR_HIGH |=> rsp.rdata[15:11] == 5'h00)
    else $error("bits 15:11 set");
endmodule
bind fpw_regs fpw_regs_sva i_fpw_regs_sva (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rsp(rsp),
  .oe_sw_mode(oe_sw_mode), .oe_pin(oe_pin), .signed_pull_offset(signed_pull_offset),
  .offset_update(offset_update), .out_enable(out_enable));
`default_nettype wire

/* verification/fpw_sink.sv */
// Partner model: consumer of the applied offset word
`timescale 1ns/1ns
`default_nettype none
module fpw_sink (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        upd,
  input  wire logic [25:0] word,
  output logic      [25:0] seen
);
  // Takes the word only on the update pulse
  always_ff @(posedge clk_sys) seen <= !rst_n ? 26'h0000000 : upd ? word : seen;
endmodule
`default_nettype wire

/* verification/tb_fpw_regs.sv */
// Testbench: register access, staged apply and output enable
`timescale 1ns/1ns
`default_nettype none
module tb_fpw_regs
  import fpw_pkg::*;
;
  logic clk_sys = 1'b0, rst_n = 1'b0, oe_sw_mode = 1'b1, oe_pin = 1'b0;
  fpw_req_t req = '0;
  fpw_rsp_t rsp;
  logic signed [25:0] signed_pull_offset;
  logic [25:0] seen;
  logic offset_update, out_enable;
  int fail_count = 0, compares = 0, cyc = 0;
  fpw_regs i_fpw_regs (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rsp(rsp),
    .oe_sw_mode(oe_sw_mode), .oe_pin(oe_pin), .signed_pull_offset(signed_pull_offset),
    .offset_update(offset_update), .out_enable(out_enable));
  fpw_sink i_fpw_sink (.clk_sys(clk_sys), .rst_n(rst_n), .upd(offset_update),
    .word(signed_pull_offset), .seen(seen));
  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc == 2 * FPW_UPD_GAP_CYC + 1000) begin
    fail_count++;
    results();
  end
  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys) #1 req = '{1'b1, 1'b0, a, d};
    @(posedge clk_sys) #1 req.wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys) #1 req = '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_sys) #1 req.rd_en = 1'b0;
    chk({9'h000, rsp.rd_valid, rsp.rdata}, {10'h001, exp});
  endtask
  task automatic results();
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    rd(FPW_ADDR_LOW, 16'h0000);
    rd(FPW_ADDR_HIGH, 16'h0000);
    wr(FPW_ADDR_LOW, 16'h1234);
    chk(signed_pull_offset, 26'h0000000);
    rd(FPW_ADDR_LOW, 16'h1234);
    wr(FPW_ADDR_HIGH, 16'hFFFF);
    chk({24'h000000, offset_update, out_enable}, 26'h0000003);
    chk({25'h0000000, signed_pull_offset < 0}, 26'h0000001);
    rd(FPW_ADDR_HIGH, 16'h07FF);
    chk(seen, 26'h3FF1234);
    oe_sw_mode = 1'b0;
    repeat (FPW_UPD_GAP_CYC) @(posedge clk_sys);
    // Bit 10 write must be dropped under pin control
    wr(FPW_ADDR_HIGH, 16'h0001);
    rd(FPW_ADDR_HIGH, 16'h0401);
    chk({25'h0000000, out_enable}, 26'h0000000);
    oe_pin = 1'b1;
    wr(8'h05, 16'hBEEF);
    rd(8'h05, 16'h0000);
    chk(signed_pull_offset, 26'h0011234);
    chk({25'h0000000, out_enable}, 26'h0000001);
    wr(FPW_ADDR_LOW, 16'hFFFF);
    repeat (FPW_UPD_GAP_CYC) @(posedge clk_sys);
    wr(FPW_ADDR_HIGH, 16'h01FF);
    chk(signed_pull_offset, FPW_FULL_SCALE);
    rst_n = 1'b0;
    @(posedge clk_sys) #1 rst_n = 1'b1;
    chk(signed_pull_offset, 26'h0000000);
    chk({25'h0000000, out_enable}, 26'h0000000);
    results();
  end
endmodule
`default_nettype wire
